// *** src/autoneg_next_page_regs.sv ***
// next-page and expansion register bank behind the management serial port
`timescale 1ns/1ps
module autoneg_next_page_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // management serial pins
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [4:0] phyAddr,
    // negotiation engine status, same clock
    input wire an_np_pkg::an_status_t anStatus,
    input wire logic energyDetectPowerDown,
    // controls to the negotiation engine and analog side
    output logic [15:0] localNextPage,
    output logic localPageWritten,
    output logic pllOff,
    output logic [15:0] analogFrontEndControl
);
    logic mdcSync;
    logic mdioInSync;
    logic [4:0] phyAddrSync;
    an_np_pkg::mgmt_req_t req;
    logic reqValid;
    logic [15:0] readData;
    logic [15:0] localPage;
    logic [15:0] partnerPage;
    logic [15:0] digitalCtrl;
    logic pageReceived;
    logic partnerAnAble;
    logic writeStrobe;
    logic readStrobe;

    pin_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({mdc, mdioIn, phyAddr}),
        .dout({mdcSync, mdioInSync, phyAddrSync})
    );

    mdio_frame u_frame (
        .clk(clk),
        .sys_rst(sys_rst),
        .mdcSync(mdcSync),
        .mdioInSync(mdioInSync),
        .phyAddr(phyAddrSync),
        .req(req),
        .reqValid(reqValid),
        .readData(readData),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe)
    );

    assign writeStrobe = reqValid & req.write;
    assign readStrobe = reqValid & ~req.write;

    // local next page: writable fields, toggle from the engine
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            localPage <= an_np_pkg::LOCAL_NP_RESET;
        else
        begin
            if (writeStrobe && req.addr == an_np_pkg::ADDR_LOCAL_NP)
                localPage <= req.data & an_np_pkg::LOCAL_NP_WMASK;
            localPage[an_np_pkg::NP_TOGGLE] <= anStatus.localToggle;
            localPage[14] <= 1'b0;
        end
    end

    // pulse tells the engine a fresh page is loaded
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            localPageWritten <= 1'b0;
        else
            localPageWritten <= writeStrobe &&
                req.addr == an_np_pkg::ADDR_LOCAL_NP;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            localNextPage <= an_np_pkg::LOCAL_NP_RESET;
        else
            localNextPage <= localPage;
    end

    // partner page captured on each received page
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            partnerPage <= '0;
        else if (anStatus.pageEvent)
            partnerPage <= anStatus.partnerPage;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            partnerAnAble <= 1'b0;
        else
            partnerAnAble <= anStatus.partnerAnAble;
    end

    // page received latch: set wins over the read clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pageReceived <= 1'b0;
        else if (anStatus.pageEvent)
            pageReceived <= 1'b1;
        else if (readStrobe && req.addr == an_np_pkg::ADDR_EXPANSION)
            pageReceived <= 1'b0;
    end

    // digital and analog control registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            digitalCtrl <= an_np_pkg::DIGITAL_RESET;
        else if (writeStrobe && req.addr == an_np_pkg::ADDR_DIGITAL_CTRL)
            digitalCtrl <= req.data;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            analogFrontEndControl <= an_np_pkg::AFE_RESET;
        else if (writeStrobe && req.addr == an_np_pkg::ADDR_AFE_CTRL)
            analogFrontEndControl <= req.data;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pllOff <= 1'b0;
        else
            pllOff <= digitalCtrl[an_np_pkg::DIG_PLL_OFF] &
                energyDetectPowerDown;
    end

    // read multiplexer; unmapped addresses read zero
    always_comb
    begin
        readData = 16'h0000;
        unique case (req.addr)
            an_np_pkg::ADDR_EXPANSION:
            begin
                readData[an_np_pkg::EXP_NP_ABLE] = 1'b1;
                readData[an_np_pkg::EXP_PAGE_RX] = pageReceived;
                readData[an_np_pkg::EXP_LP_AN_ABLE] = partnerAnAble;
            end
            an_np_pkg::ADDR_LOCAL_NP:
                readData = localPage;
            an_np_pkg::ADDR_PARTNER_NP:
                readData = partnerPage;
            an_np_pkg::ADDR_DIGITAL_CTRL:
                readData = digitalCtrl;
            an_np_pkg::ADDR_AFE_CTRL:
                readData = analogFrontEndControl;
            default:
                readData = 16'h0000;
        endcase
    end
endmodule

// *** src/an_np_pkg.sv ***
// package: register map, field positions, reset values and carrier types
package an_np_pkg;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_LOCAL_NP = 5'h07;
    localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
    localparam logic [4:0] ADDR_DIGITAL_CTRL = 5'h10;
    localparam logic [4:0] ADDR_AFE_CTRL = 5'h11;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN_ABLE = 0;
    localparam int NP_MORE = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG_PAGE = 13;
    localparam int NP_COMPLY = 12;
    localparam int NP_TOGGLE = 11;
    localparam int NP_MSG_MSB = 10;
    localparam int DIG_PLL_OFF = 4;
    localparam logic [15:0] LOCAL_NP_RESET = 16'h2001;
    localparam logic [15:0] LOCAL_NP_WMASK = 16'hb7ff;
    localparam logic [15:0] DIGITAL_RESET = 16'h0000;
    localparam logic [15:0] AFE_RESET = 16'h0000;
    localparam logic [1:0] MDIO_START = 2'b01;
    localparam logic [1:0] MDIO_OP_WRITE = 2'b01;
    localparam logic [1:0] MDIO_OP_READ = 2'b10;
    localparam logic [5:0] MDIO_FRAME_BITS = 6'd32;

    // one management access decoded from the serial frame
    typedef struct packed {
        logic write;
        logic [4:0] addr;
        logic [15:0] data;
    } mgmt_req_t;

    // page and ability status from the negotiation engine
    typedef struct packed {
        logic pageEvent;
        logic partnerAnAble;
        logic [15:0] partnerPage;
        logic localToggle;
    } an_status_t;
endpackage

// *** src/pin_sync.sv ***
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// *** src/mdio_frame.sv ***
// management serial frame engine: clause-22 read and write frames
`timescale 1ns/1ps
module mdio_frame (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // synchronised pins
    input wire logic mdcSync,
    input wire logic mdioInSync,
    input wire logic [4:0] phyAddr,
    // decoded access
    output an_np_pkg::mgmt_req_t req,
    output logic reqValid,
    input wire logic [15:0] readData,
    // serial output
    output logic mdioOut,
    output logic mdioOe
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_HEAD = 4'b0010,
        S_READ = 4'b0100,
        S_WRITE = 4'b1000
    } frame_state_t;

    frame_state_t state;
    logic mdcPrev;
    logic [5:0] ones;
    logic [5:0] count;
    logic [15:0] shift;
    logic [15:0] readShift;
    logic rise;
    logic fall;

    assign rise = mdcSync & ~mdcPrev;
    assign fall = ~mdcSync & mdcPrev;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mdcPrev <= 1'b0;
        else
            mdcPrev <= mdcSync;
    end

    // preamble, header capture and data phases
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= S_IDLE;
            ones <= '0;
            count <= '0;
            shift <= '0;
            readShift <= '0;
            req <= '0;
            reqValid <= 1'b0;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
        end
        else
        begin
            reqValid <= 1'b0;
            unique case (state)
                S_IDLE:
                begin
                    mdioOe <= 1'b0;
                    if (rise)
                    begin
                        if (mdioInSync)
                            ones <= (ones == 6'd32) ? ones : ones + 6'd1;
                        else if (ones == 6'd32)
                        begin
                            state <= S_HEAD;
                            count <= 6'd1;
                            shift <= 16'h0000;
                            ones <= '0;
                        end
                        else
                            ones <= '0;
                    end
                end
                S_HEAD:
                    if (rise)
                    begin
                        shift <= {shift[14:0], mdioInSync};
                        count <= count + 6'd1;
                        if (count == 6'd13)
                        begin
                            // shift holds start[1], op[2], phy[5], reg[4]
                            req.addr <= {shift[3:0], mdioInSync};
                            req.write <=
                                shift[10:9] == an_np_pkg::MDIO_OP_WRITE;
                            if (shift[11] != an_np_pkg::MDIO_START[0])
                                state <= S_IDLE;
                            else if (shift[8:4] != phyAddr)
                                state <= S_IDLE;
                            else if (shift[10:9] == an_np_pkg::MDIO_OP_READ)
                            begin
                                req.write <= 1'b0;
                                reqValid <= 1'b1;
                                state <= S_READ;
                                count <= '0;
                            end
                            else if (shift[10:9] == an_np_pkg::MDIO_OP_WRITE)
                            begin
                                state <= S_WRITE;
                                count <= '0;
                            end
                            else
                                state <= S_IDLE;
                        end
                    end
                S_READ:
                begin
                    // capture on the strobe edge, before any clear-on-read
                    if (reqValid)
                        readShift <= readData;
                    if (fall)
                    begin
                        count <= count + 6'd1;
                        if (count == 6'd1)
                        begin
                            mdioOe <= 1'b1;
                            mdioOut <= 1'b0;
                        end
                        else if (count >= 6'd2 && count <= 6'd17)
                        begin
                            mdioOut <= readShift[15];
                            readShift <= {readShift[14:0], 1'b0};
                        end
                        else if (count == 6'd18)
                        begin
                            mdioOe <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                end
                S_WRITE:
                    if (rise)
                    begin
                        count <= count + 6'd1;
                        shift <= {shift[14:0], mdioInSync};
                        if (count == 6'd17)
                        begin
                            req.write <= 1'b1;
                            req.data <= {shift[14:0], mdioInSync};
                            reqValid <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
            endcase
        end
    end
endmodule

// *** testbench/np_regs_checker.sv ***
// assertions on the next-page register bank ports
`timescale 1ns/1ps
module np_regs_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial pins
    input wire logic mdc,
    input wire logic mdioOut,
    input wire logic mdioOe,
    // engine side
    input wire an_np_pkg::an_status_t anStatus,
    input wire logic energyDetectPowerDown,
    input wire logic [15:0] localNextPage,
    input wire logic localPageWritten,
    input wire logic pllOff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_np_reset_val:
        assert property ($past(sys_rst) |-> localNextPage == 16'h2001
            && !pllOff) else $error("bad value after reset");
    a_toggle_follow:
        assert property ($stable(anStatus.localToggle)[*4] |->
            localNextPage[11] == anStatus.localToggle)
            else $error("toggle not shown");
    a_reserved_zero:
        assert property (localNextPage[14] == 1'b0)
            else $error("bit 14 not zero");
    a_change_on_write:
        assert property ($changed(localNextPage & 16'hb7ff) |->
            localPageWritten || $past(localPageWritten)
            || $past(localPageWritten, 2)) else $error("page changed");
    a_pulse_single:
        assert property (localPageWritten |=> !localPageWritten)
            else $error("write pulse too long");
    a_pll_gate:
        assert property (!$past(energyDetectPowerDown) |-> !pllOff)
            else $error("pll off outside power-down");
    a_pll_hold:
        assert property ((energyDetectPowerDown && !mdc)[*8] |->
            $stable(pllOff)) else $error("pll off changed");
    a_data_on_fall:
        assert property (mdioOe && $changed(mdioOut) |-> !mdc)
            else $error("data moved while clock high");
    a_turn_zero:
        assert property ($rose(mdioOe) |-> !mdioOut ##1 mdioOe[*7])
            else $error("bad turnaround");
    c_read: cover property ($rose(mdioOe));
    c_write: cover property (localPageWritten);
    c_pll: cover property (pllOff);
endmodule

// *** testbench/mdio_station.sv ***
// management station model driving clause-22 frames
`timescale 1ns/1ps
module mdio_station (
    // clock
    input wire logic clk,
    // serial pins
    output logic mdc,
    output logic mgmtOut,
    output logic mgmtOe,
    input wire logic mdioWire
);
    logic smp;
    int hc = 8;
    initial
    begin
        mdc = 1'b0;
        mgmtOut = 1'b0;
        mgmtOe = 1'b0;
    end
    // set up while mdc low, sample just before the rise
    task automatic one(input logic b, input logic oe);
        mdc <= 1'b0;
        mgmtOut <= b;
        mgmtOe <= oe;
        repeat (hc) @(posedge clk);
        smp = mdioWire;
        mdc <= 1'b1;
        repeat (hc) @(posedge clk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hd;
        logic w;
        hd = {2'b01, op, pa, ra};
        w = (op == 2'b01);
        repeat (32) one(1'b1, 1'b1);
        for (int i = 13; i >= 0; i--) one(hd[i], 1'b1);
        one(1'b1, w);
        one(1'b0, w);
        for (int i = 15; i >= 0; i--)
        begin
            one(wd[i], w);
            rd[i] = smp;
        end
        // clock stands still between frames
        mdc <= 1'b0;
        mgmtOe <= 1'b0;
        repeat (2 * hc) @(posedge clk);
    endtask
endmodule

// *** testbench/tb_top.sv ***
// bench for the next-page register bank
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic sys_rst;
    logic mdc;
    logic mgmtOut;
    logic mgmtOe;
    logic mdioWire;
    logic mdioOut;
    logic mdioOe;
    logic [4:0] phyAddr;
    an_np_pkg::an_status_t anStatus;
    logic energyDetectPowerDown;
    logic [15:0] localNextPage;
    logic localPageWritten;
    logic pllOff;
    logic [15:0] analogFrontEndControl;
    logic [15:0] rd;
    int err_count;
    int total_checks;
    int cycles;
    int pulses;
    // released line is pulled up
    assign mdioWire = mdioOe ? mdioOut : (mgmtOe ? mgmtOut : 1'b1);
    autoneg_next_page_regs u_autoneg_next_page_regs (
        .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioWire),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(phyAddr),
        .anStatus(anStatus), .energyDetectPowerDown(energyDetectPowerDown),
        .localNextPage(localNextPage), .localPageWritten(localPageWritten),
        .pllOff(pllOff), .analogFrontEndControl(analogFrontEndControl));
    mdio_station u_mdio_station (.clk(clk), .mdc(mdc), .mgmtOut(mgmtOut),
        .mgmtOe(mgmtOe), .mdioWire(mdioWire));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (localPageWritten === 1'b1) pulses++;
        if (cycles == 60000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
        u_mdio_station.frame(2'b10, 5'h03, ra, 16'h0000, rd);
        check(rd, exp);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        u_mdio_station.frame(2'b01, 5'h03, ra, wd, rd);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        rd_chk(5'h06, 16'h0004);
        rd_chk(5'h07, 16'h2001);
        rd_chk(5'h08, 16'h0000);
        rd_chk(5'h10, 16'h0000);
        rd_chk(5'h11, 16'h0000);
        check(analogFrontEndControl, 16'h0000);
        check(localNextPage, 16'h2001);
    endtask
    task automatic t_local();
        int p;
        p = pulses;
        wr(5'h07, 16'hffff);
        rd_chk(5'h07, 16'hb7ff);
        check(localNextPage, 16'hb7ff);
        check(16'(pulses - p), 16'h0001);
        wr(5'h07, 16'h0000);
        rd_chk(5'h07, 16'h0000);
    endtask
    task automatic t_toggle();
        anStatus.localToggle <= 1'b1;
        rd_chk(5'h07, 16'h0800);
        anStatus.localToggle <= 1'b0;
    endtask
    task automatic t_page();
        logic [15:0] pg [2];
        pg = '{16'hdbff, 16'h0400};
        foreach (pg[i])
        begin
            anStatus.partnerAnAble <= 1'b1;
            anStatus.partnerPage <= pg[i];
            anStatus.pageEvent <= 1'b1;
            @(posedge clk);
            anStatus.pageEvent <= 1'b0;
            rd_chk(5'h06, 16'h0007);
            rd_chk(5'h06, 16'h0005);
            rd_chk(5'h08, pg[i]);
        end
        anStatus.partnerAnAble <= 1'b0;
    endtask
    task automatic t_pll();
        wr(5'h10, 16'h0010);
        energyDetectPowerDown <= 1'b1;
        repeat (10) @(posedge clk);
        check(16'(pllOff), 16'h0001);
        energyDetectPowerDown <= 1'b0;
        repeat (10) @(posedge clk);
        check(16'(pllOff), 16'h0000);
        rd_chk(5'h10, 16'h0010);
        wr(5'h10, 16'h0000);
        energyDetectPowerDown <= 1'b1;
        repeat (10) @(posedge clk);
        check(16'(pllOff), 16'h0000);
        energyDetectPowerDown <= 1'b0;
    endtask
    task automatic t_refuse();
        wr(5'h11, 16'h5a5a);
        u_mdio_station.hc = 12;
        u_mdio_station.frame(2'b10, 5'h04, 5'h06, 16'h0000, rd);
        check(rd, 16'hffff);
        u_mdio_station.frame(2'b11, 5'h03, 5'h11, 16'h0000, rd);
        u_mdio_station.hc = 8;
        rd_chk(5'h11, 16'h5a5a);
        check(analogFrontEndControl, 16'h5a5a);
        rd_chk(5'h1f, 16'h0000);
    endtask
    initial
    begin
        sys_rst = 1'b1;
        phyAddr = 5'h03;
        anStatus = '0;
        energyDetectPowerDown = 1'b0;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        pulses = 0;
        do_reset();
        t_reset();
        t_local();
        t_toggle();
        t_page();
        t_pll();
        t_refuse();
        do_reset();
        t_reset();
        close_out();
    end
endmodule
bind autoneg_next_page_regs np_regs_checker u_np_regs_checker (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .anStatus(anStatus),
    .energyDetectPowerDown(energyDetectPowerDown),
    .localNextPage(localNextPage), .localPageWritten(localPageWritten),
    .pllOff(pllOff));
